// ==== rtl/miec_pkg.sv ====
// Shared constants and carriers for the idle-entry control block
package miec_pkg;

  // Bus geometry
  localparam int unsigned MIEC_ADDR_W = 4;
  localparam int unsigned MIEC_DATA_W = 32;
  localparam int unsigned MIEC_BE_W = 4;

  // Register byte offsets
  localparam logic [MIEC_ADDR_W-1:0] MIEC_OFF_CFG = 4'h0;
  localparam logic [MIEC_ADDR_W-1:0] MIEC_OFF_STATUS = 4'h4;

  // Field positions in the idle-entry configuration register
  localparam int unsigned MIEC_BIT_IDLE_REQ = 11;
  localparam int unsigned MIEC_BIT_WAKE_SEL = 10;
  localparam int unsigned MIEC_BIT_TIMER_GATE = 9;
  localparam int unsigned MIEC_BIT_RSVD8 = 8;
  localparam int unsigned MIEC_BIT_PLL_EN = 7;
  localparam int unsigned MIEC_BIT_IFACE_GATE = 6;
  localparam int unsigned MIEC_BIT_WDT_GATE = 0;

  // Byte lanes that carry the low and high configuration bytes
  localparam int unsigned MIEC_LANE_LO = 0;
  localparam int unsigned MIEC_LANE_HI = 1;

  // Reset values of the configuration fields
  localparam logic MIEC_RST_IDLE_REQ = 1'b1;
  localparam logic MIEC_RST_WAKE_SEL = 1'b1;
  localparam logic MIEC_RST_TIMER_GATE = 1'b0;
  localparam logic MIEC_RST_RSVD8 = 1'b0;
  localparam logic MIEC_RST_PLL_EN = 1'b0;
  localparam logic MIEC_RST_IFACE_GATE = 1'b0;
  localparam logic MIEC_RST_WDT_GATE = 1'b0;

  // Clock gating sequencer states
  typedef enum logic [1:0] {
    st_run,
    st_idle,
    st_restore
  } miec_state_t;

  // Software-visible configuration
  typedef struct packed {
    logic idle_req;
    logic wake_sel;
    logic timer_gate;
    logic rsvd8;
    logic pll_en;
    logic iface_gate;
    logic wdt_gate;
  } miec_cfg_t;

  // Conditions reported by the rest of the subsystem
  typedef struct packed {
    logic dsp_global_idle;
    logic dma_active;
    logic tc_local_bus_en;
    logic posted_write_pending;
    logic periph_clks_stopped;
  } miec_cond_t;

  // Clock enables handed to the clock gates
  typedef struct packed {
    logic mpu_core_clk;
    logic timer_clk;
    logic periph_bridge_clk;
    logic dma_clk;
    logic traffic_ctrl_clk;
    logic watchdog_clk;
  } miec_clk_en_t;

endpackage

// ==== rtl/miec_idle_ctrl.sv ====
// Operation
// - Writing one starts idle; reads one when idle
// - Idle request cleared by reset or interrupt; here reset sets it to one
// - Reading zero means active or wait-for-interrupt idle
// - Select zero: interrupt plus low wake pin
// - Select one: any interrupt or wake condition
// - Timer clock stops with core when selected
// - Upper four bits ignore writes, read zero
// - PLL idles only when DSP, MPU idle
// - Also DMA quiet, no posted write, clocks stopped; here DMA may stay active while the traffic controller local bus is disabled
// - PLL enable zero keeps PLL always active
// - Interface clocks stop with core when selected
// - Interface gate zero keeps interface clocks running
// - Watchdog mode never gates watchdog clock
// - Watchdog gate bit stops its clock in idle
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module miec_idle_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [miec_pkg::MIEC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [miec_pkg::MIEC_DATA_W-1:0] avs_writedata,
  input wire logic [miec_pkg::MIEC_BE_W-1:0] avs_byteenable,
  output logic [miec_pkg::MIEC_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // MPU and interrupt handler
  input wire logic mpu_irq_assert_n,
  input wire logic mpu_wfi,
  input wire logic watchdog_mode,
  // External wake pin and chip-level wake request
  input wire logic chip_wake_n,
  input wire logic chip_wake_cond,
  // Subsystem idle conditions
  input wire miec_pkg::miec_cond_t cond,
  // Clock control outputs
  output miec_pkg::miec_clk_en_t clk_en,
  output logic main_pll_idle,
  output logic chip_idle_exit
);
  import miec_pkg::*;

  // Configuration register contents
  miec_cfg_t cfg_q;
  // Sequencer state
  miec_state_t state_q;
  miec_state_t state_d;
  // Two-flop synchroniser for the wake pin
  logic wake_meta_q;
  logic wake_sync_n_q;
  // Interrupt seen while idle, needed when the pin must also go low
  logic irq_seen_q;
  // Bus acknowledge stage
  logic ack_q;
  logic [MIEC_DATA_W-1:0] rdata_q;
  // Registered clock enables and status outputs
  miec_clk_en_t clk_en_q;
  logic pll_idle_q;
  logic chip_exit_q;

  // Decoded helpers
  logic irq_now;
  logic idle_source;
  logic bus_req;
  logic cfg_wr;
  logic wake_ok;
  logic gated;
  logic pll_cond;

  // Byte-lane aware write decode, used for both configuration bytes
  function automatic logic lane_wr(input logic [MIEC_BE_W-1:0] be, input int unsigned lane);
    lane_wr = be[lane];
  endfunction

  // Configuration word as seen by software
  function automatic logic [MIEC_DATA_W-1:0] cfg_word(input miec_cfg_t c);
    logic [MIEC_DATA_W-1:0] w;
    w = '0;
    w[MIEC_BIT_IDLE_REQ] = c.idle_req;
    w[MIEC_BIT_WAKE_SEL] = c.wake_sel;
    w[MIEC_BIT_TIMER_GATE] = c.timer_gate;
    w[MIEC_BIT_RSVD8] = c.rsvd8;
    w[MIEC_BIT_PLL_EN] = c.pll_en;
    w[MIEC_BIT_IFACE_GATE] = c.iface_gate;
    w[MIEC_BIT_WDT_GATE] = c.wdt_gate;
    cfg_word = w;
  endfunction

  // Interrupt line from the handler runs on this clock, so no synchroniser
  assign irq_now = ~mpu_irq_assert_n;
  // Idle by request bit or by wait-for-interrupt
  assign idle_source = cfg_q.idle_req | mpu_wfi;
  // One wait state per access keeps read data registered
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_q;
  assign cfg_wr = avs_write & ack_q & (avs_address == MIEC_OFF_CFG);
  assign avs_readdata = rdata_q;

  // Wake pin synchroniser; only the second flop is read
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wake_meta_q <= 1'b1;
      wake_sync_n_q <= 1'b1;
    end else begin
      wake_meta_q <= chip_wake_n;
      wake_sync_n_q <= wake_meta_q;
    end
  end

  // Bus acknowledge: high for one cycle after a request shows up
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  // Read data captured in the wait cycle, presented while waitrequest is low
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else if (avs_read && !ack_q) begin
      unique case (avs_address)
        // Upper bits 15..12 and unused bits read zero
        MIEC_OFF_CFG: begin
          rdata_q <= cfg_word(cfg_q);
        end
        // Live view of the sequencer and the enables it drives
        MIEC_OFF_STATUS: begin
          rdata_q <= {{(MIEC_DATA_W-12){1'b0}}, state_q, irq_seen_q, wake_sync_n_q,
                      chip_exit_q, pll_idle_q, clk_en_q};
        end
        // Unmapped offsets answer with zero
        default: begin
          rdata_q <= '0;
        end
      endcase
    end
  end

  // Idle request bit: software or reset sets it, an interrupt clears it.
  // The interrupt wins over a simultaneous write so it is never swallowed.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q.idle_req <= MIEC_RST_IDLE_REQ;
    end else if (irq_now) begin
      cfg_q.idle_req <= 1'b0;
    end else if (cfg_wr && lane_wr(avs_byteenable, MIEC_LANE_HI) &&
                 avs_writedata[MIEC_BIT_IDLE_REQ]) begin
      cfg_q.idle_req <= 1'b1;
    end
  end

  // Plain read/write configuration fields, byte-lane gated
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q.wake_sel <= MIEC_RST_WAKE_SEL;
      cfg_q.timer_gate <= MIEC_RST_TIMER_GATE;
      cfg_q.rsvd8 <= MIEC_RST_RSVD8;
      cfg_q.pll_en <= MIEC_RST_PLL_EN;
      cfg_q.iface_gate <= MIEC_RST_IFACE_GATE;
      cfg_q.wdt_gate <= MIEC_RST_WDT_GATE;
    end else if (cfg_wr) begin
      // High byte: wake select, timer gate, reserved bit 8
      if (lane_wr(avs_byteenable, MIEC_LANE_HI)) begin
        cfg_q.wake_sel <= avs_writedata[MIEC_BIT_WAKE_SEL];
        cfg_q.timer_gate <= avs_writedata[MIEC_BIT_TIMER_GATE];
        // Stored as written; software is expected to keep it zero
        cfg_q.rsvd8 <= avs_writedata[MIEC_BIT_RSVD8];
      end
      // Low byte: PLL enable, interface gate, watchdog gate
      if (lane_wr(avs_byteenable, MIEC_LANE_LO)) begin
        cfg_q.pll_en <= avs_writedata[MIEC_BIT_PLL_EN];
        cfg_q.iface_gate <= avs_writedata[MIEC_BIT_IFACE_GATE];
        cfg_q.wdt_gate <= avs_writedata[MIEC_BIT_WDT_GATE];
      end
    end
  end

  // Remember an interrupt taken during idle until the wake pin agrees
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_seen_q <= 1'b0;
    end else if (state_q != st_idle) begin
      irq_seen_q <= 1'b0;
    end else if (irq_now) begin
      irq_seen_q <= 1'b1;
    end
  end

  // Exit test: any interrupt, or interrupt plus a low wake pin
  always_comb begin
    if (cfg_q.wake_sel) begin
      wake_ok = irq_now;
    end else begin
      wake_ok = (irq_now | irq_seen_q) & ~wake_sync_n_q;
    end
  end

  // Sequencer: run, idle with clocks gated, restore clocks, then run
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      // Enter idle on request bit or wait-for-interrupt
      st_run: begin
        if (idle_source && !irq_now) begin
          state_d = st_idle;
        end
      end
      // Stay gated until the selected wake condition holds
      st_idle: begin
        if (wake_ok) begin
          state_d = st_restore;
        end
      end
      // Subsystem clocks come back one cycle ahead of the core
      st_restore: begin
        state_d = st_run;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= st_run;
    end else begin
      state_q <= state_d;
    end
  end

  // Gating is applied only in the idle state itself
  assign gated = (state_d == st_idle);

  // Clock enables; registered so the gates see clean levels
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clk_en_q <= '1;
    end else begin
      // Core restarts only after the restore cycle has passed
      clk_en_q.mpu_core_clk <= (state_d == st_run);
      clk_en_q.timer_clk <= ~(gated & cfg_q.timer_gate);
      clk_en_q.periph_bridge_clk <= ~(gated & cfg_q.iface_gate);
      clk_en_q.dma_clk <= ~(gated & cfg_q.iface_gate);
      clk_en_q.traffic_ctrl_clk <= ~(gated & cfg_q.iface_gate);
      // A watchdog must keep counting whatever the gate bit says
      clk_en_q.watchdog_clk <= watchdog_mode | ~(gated & cfg_q.wdt_gate);
    end
  end
  assign clk_en = clk_en_q;

  // Every condition for letting the main PLL idle
  assign pll_cond = cond.dsp_global_idle & (state_q == st_idle) &
                    (~cond.dma_active | ~cond.tc_local_bus_en) &
                    ~cond.posted_write_pending & cond.periph_clks_stopped;

  // PLL idle request, held off entirely while the enable is clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pll_idle_q <= 1'b0;
    end else begin
      pll_idle_q <= cfg_q.pll_en & pll_cond;
    end
  end
  assign main_pll_idle = pll_idle_q;

  // Chip-level wake: pin must agree unless the select bit is set
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      chip_exit_q <= 1'b0;
    end else begin
      chip_exit_q <= chip_wake_cond & (cfg_q.wake_sel | ~wake_sync_n_q);
    end
  end
  assign chip_idle_exit = chip_exit_q;

  // Checks
  property p_req_set;
    @(posedge sys_clk) disable iff (!nrst)
      (cfg_wr && avs_byteenable[MIEC_LANE_HI] && avs_writedata[MIEC_BIT_IDLE_REQ] && !irq_now)
      |=> cfg_q.idle_req;
  endproperty
  a_req_set: assert property (p_req_set) else $error("idle request not set by write");

  property p_req_clr;
    @(posedge sys_clk) disable iff (!nrst)
      irq_now |=> !cfg_q.idle_req;
  endproperty
  a_req_clr: assert property (p_req_clr) else $error("idle request not cleared by irq");

  property p_read_idle;
    @(posedge sys_clk) disable iff (!nrst)
      (avs_read && !ack_q && avs_address == MIEC_OFF_CFG)
      |=> avs_readdata[MIEC_BIT_IDLE_REQ] == $past(cfg_q.idle_req) && !avs_waitrequest;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("idle bit read wrong");

  property p_pin_hold;
    @(posedge sys_clk) disable iff (!nrst)
      (state_q == st_idle && !cfg_q.wake_sel && wake_sync_n_q) |=> state_q == st_idle;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("left idle with wake pin high");

  property p_any_irq;
    @(posedge sys_clk) disable iff (!nrst)
      (state_q == st_idle && cfg_q.wake_sel && irq_now) |=> state_q == st_restore ##1 clk_en.mpu_core_clk;
  endproperty
  a_any_irq: assert property (p_any_irq) else $error("irq did not end idle");

  property p_timer;
    @(posedge sys_clk) disable iff (!nrst)
      (state_q == st_idle && state_d == st_idle)
      |=> clk_en.timer_clk == !$past(cfg_q.timer_gate);
  endproperty
  a_timer: assert property (p_timer) else $error("timer clock gating wrong");

  property p_rsvd_hi;
    @(posedge sys_clk) disable iff (!nrst)
      (avs_read && !ack_q && avs_address == MIEC_OFF_CFG) |=> avs_readdata[15:12] == 4'h0;
  endproperty
  a_rsvd_hi: assert property (p_rsvd_hi) else $error("upper bits not zero");

  property p_pll;
    @(posedge sys_clk) disable iff (!nrst)
      main_pll_idle |-> $past(pll_cond) && $past(cfg_q.pll_en);
  endproperty
  a_pll: assert property (p_pll) else $error("pll idled without conditions");

  property p_pll_off;
    @(posedge sys_clk) disable iff (!nrst)
      !cfg_q.pll_en |=> !main_pll_idle;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("pll idled while disabled");

  property p_iface;
    @(posedge sys_clk) disable iff (!nrst)
      (state_d == st_idle) |=> clk_en.dma_clk == !$past(cfg_q.iface_gate);
  endproperty
  a_iface: assert property (p_iface) else $error("interface gating wrong");

  property p_wdt;
    @(posedge sys_clk) disable iff (!nrst)
      watchdog_mode |=> clk_en.watchdog_clk;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog clock gated in watchdog mode");

  property p_resume;
    @(posedge sys_clk) disable iff (!nrst)
      $rose(clk_en.mpu_core_clk) |-> $past(clk_en.periph_bridge_clk) && $past(clk_en.timer_clk);
  endproperty
  a_resume: assert property (p_resume) else $error("core resumed before clocks");

endmodule

`default_nettype wire

// ==== tb/miec_partner.sv ====
`timescale 1ns/1ps
`default_nettype none

// Interrupt handler and core: irq held until the core runs again
module miec_partner (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Bench commands, one-cycle pulses
  input wire logic raise_irq,
  input wire logic do_wfi,
  // Core clock as the block gates it
  input wire logic core_on,
  // Lines toward the block
  output logic mpu_irq_assert_n,
  output logic mpu_wfi
);
  // Irq stays low until serviced, so a slow wake never loses it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mpu_irq_assert_n <= 1'b1;
    end else if (raise_irq) begin
      mpu_irq_assert_n <= 1'b0;
    end else if (core_on) begin
      mpu_irq_assert_n <= 1'b1;
    end
  end

  // Core leaves wait-for-interrupt once it runs with irq seen
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mpu_wfi <= 1'b0;
    end else if (do_wfi) begin
      mpu_wfi <= 1'b1;
    end else if (!mpu_irq_assert_n && core_on) begin
      mpu_wfi <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ==== tb/tb_mpu_idle_entry_control.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_mpu_idle_entry_control;
  import miec_pkg::*;
  // Clock, reset, bus
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h3;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  // Far side and subsystem
  logic raise_irq = 1'b0;
  logic do_wfi = 1'b0;
  logic irq_n;
  logic wfi;
  logic watchdog_mode = 1'b0;
  logic chip_wake_n = 1'b1;
  logic chip_wake_cond = 1'b0;
  miec_cond_t cond = '0;
  miec_clk_en_t clk_en;
  miec_clk_en_t prev;
  logic main_pll_idle;
  logic chip_idle_exit;
  // Bookkeeping
  int n_mismatch = 0;
  int checked = 0;
  logic [31:0] rd;
  // PLL condition table and expected idle permission
  logic [4:0] ctab [6] = '{5'h11, 5'h19, 5'h1d, 5'h13, 5'h10, 5'h01};
  logic ptab [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

  always #4 sys_clk = ~sys_clk;

  miec_idle_ctrl u_miec_idle_ctrl (
    .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mpu_irq_assert_n(irq_n), .mpu_wfi(wfi),
    .watchdog_mode(watchdog_mode), .chip_wake_n(chip_wake_n),
    .chip_wake_cond(chip_wake_cond), .cond(cond), .clk_en(clk_en),
    .main_pll_idle(main_pll_idle), .chip_idle_exit(chip_idle_exit));

  miec_partner u_miec_partner (
    .sys_clk(sys_clk), .nrst(nrst), .raise_irq(raise_irq), .do_wfi(do_wfi),
    .core_on(clk_en.mpu_core_clk), .mpu_irq_assert_n(irq_n), .mpu_wfi(wfi));

  // Verdict and end of run
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Register read value compare
  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask

  // Port level compare
  task chk_port(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t port got %h exp %h", $time, got, exp);
    end
  endtask

  // One bus cycle, held until waitrequest is seen low
  task bus(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= ~we;
    n = 0;
    // Waitrequest and read data are both taken at the completing edge
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      n_mismatch++;
      tally_and_finish;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Let cycles pass, then settle
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Bounded wait for the core clock; prev keeps the sample before it
  task wait_core(input logic v);
    int n;
    n = 0;
    do begin
      prev = clk_en;
      @(posedge sys_clk);
      #1;
      n++;
    end while (clk_en.mpu_core_clk !== v && n < 30);
    // Judge by the level itself, so a late but valid change still counts
    if (clk_en.mpu_core_clk !== v) begin
      n_mismatch++;
      tally_and_finish;
    end
  endtask

  // Pulse a command to the partner: wfi or interrupt
  task fire(input logic w);
    @(posedge sys_clk);
    if (w) begin
      do_wfi <= 1'b1;
    end else begin
      raise_irq <= 1'b1;
    end
    @(posedge sys_clk);
    do_wfi <= 1'b0;
    raise_irq <= 1'b0;
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    // Idle request is set out of reset, so the core parks at once
    bus(1'b0, 4'h0, 32'h0);
    chk_reg(rd, 32'h0c00);
    cyc(1);
    chk_port({2'b0, clk_en}, 8'h1f);
    bus(1'b0, 4'h8, 32'h0);
    chk_reg(rd, 32'h0);
    fire(1'b0);
    wait_core(1'b1);
    chk_port({4'h0, prev[4:1]}, 8'h0f);
    bus(1'b0, 4'h0, 32'h0);
    chk_reg(rd, 32'h0400);
    // All gates on, upper bits written high, reserved bit left zero
    bus(1'b1, 4'h0, 32'hf6c1);
    bus(1'b0, 4'h0, 32'h0);
    chk_reg(rd, 32'h06c1);
    @(posedge sys_clk);
    cond <= 5'h11;
    fire(1'b1);
    wait_core(1'b0);
    cyc(1);
    chk_port({2'b0, clk_en}, 8'h00);
    bus(1'b0, 4'h0, 32'h0);
    chk_reg(rd, 32'h06c1);
    // Status: idle state, synced pin high, PLL idle granted, all enables off
    bus(1'b0, 4'h4, 32'h0);
    chk_reg(rd, 32'h0540);
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      cond <= ctab[i];
      cyc(3);
      chk_port({7'h0, main_pll_idle}, {7'h0, ptab[i]});
    end
    @(posedge sys_clk);
    watchdog_mode <= 1'b1;
    cyc(3);
    chk_port({7'h0, clk_en.watchdog_clk}, 8'h01);
    fire(1'b0);
    wait_core(1'b1);
    chk_port({4'h0, prev[4:1]}, 8'h0f);
    // All other PLL conditions met but the core runs, so no PLL idle
    @(posedge sys_clk);
    cond <= 5'h11;
    cyc(3);
    chk_port({7'h0, main_pll_idle}, 8'h00);
    // Pin-qualified wake with PLL idle disabled
    @(posedge sys_clk);
    watchdog_mode <= 1'b0;
    cond <= 5'h11;
    chip_wake_cond <= 1'b1;
    bus(1'b1, 4'h0, 32'h0800);
    wait_core(1'b0);
    cyc(3);
    chk_port({7'h0, main_pll_idle}, 8'h00);
    chk_port({7'h0, chip_idle_exit}, 8'h00);
    chk_port({2'b0, clk_en}, 8'h1f);
    fire(1'b0);
    cyc(8);
    chk_port({7'h0, clk_en.mpu_core_clk}, 8'h00);
    @(posedge sys_clk);
    chip_wake_n <= 1'b0;
    wait_core(1'b1);
    chk_port({7'h0, chip_idle_exit}, 8'h01);
    @(posedge sys_clk);
    chip_wake_n <= 1'b1;
    bus(1'b1, 4'h0, 32'h0400);
    cyc(4);
    chk_port({7'h0, chip_idle_exit}, 8'h01);
    tally_and_finish;
  end
endmodule

`default_nettype wire
